// *** hdl/rxs_pkg.sv ***
// constants, field positions and state codes of the receive status block
package rxs_pkg;
  localparam int STAT_AW = 4;
  localparam int DATA_AW = 9;
  localparam int ST_FILT = 30;
  localparam int ST_LEN_LSB = 16;
  localparam int ST_LEN_MSB = 29;
  localparam int ST_ERRSUM = 15;
  localparam int ST_BCAST = 13;
  localparam int ST_LENMIS = 12;
  localparam int ST_RUNT = 11;
  localparam int ST_MCAST = 10;
  localparam int ST_LONG = 7;
  localparam int ST_LATE = 6;
  localparam int ST_TYPE = 5;
  localparam int ST_WDOG = 4;
  localparam int ST_MIIERR = 3;
  localparam int ST_DRIB = 2;
  localparam int ST_CRC = 1;
  localparam int CR_RECEIVE_ENABLE_BIT = 2;
  localparam int CR_PASSBAD = 16;
  localparam logic [13:0] RUNT_BYTES = 14'h0040;
  localparam logic [13:0] MAX_BYTES = 14'h05ee;
  localparam logic [13:0] WDOG_BYTES = 14'h0800;
  localparam logic [13:0] MIN_TYPE_BYTES = 14'h000e;
  localparam logic [13:0] OVH_BYTES = 14'h0012;
  localparam logic [13:0] MIN_PAYLOAD = 14'h002e;
  localparam logic [13:0] CNT_MAX = 14'h3fff;
  localparam logic [13:0] DEST_BYTES = 14'h0006;
  localparam logic [13:0] LT_HI_BYTE = 14'h000c;
  localparam logic [13:0] LT_LO_BYTE = 14'h000d;
  localparam logic [15:0] TYPE_MAX = 16'h05dc;
  localparam logic [2:0] DRIB_MII = 3'h4;
  localparam logic [2:0] DRIB_10M = 3'h3;
  localparam logic [7:0] BCAST_BYTE = 8'hff;
  localparam logic [3:0] SW_CTRL = 4'h0;
  localparam logic [3:0] SW_STAT = 4'h4;
  localparam logic [3:0] SW_SWORD = 4'h8;
  localparam logic [3:0] SW_DWORD = 4'hc;
  localparam int C_EN = 0;
  localparam int C_PB = 1;
  localparam int C_FSTAT = 4;
  localparam int C_FDATA = 5;
  localparam int C_FLUSH = 6;
  localparam int C_ACK = 7;
  localparam int C_SRST = 8;
  localparam logic [31:0] CTRL_RST = 32'h0;
  typedef enum logic [2:0] {RX_RUN = 3'b001, RX_STOPPING = 3'b010, RX_HALTED = 3'b100} rxs_rx_e;
  typedef enum logic [2:0] {H_IDLE = 3'b001, H_LO = 3'b010, H_HI = 3'b100} rxs_host_e;
endpackage : rxs_pkg

// *** hdl/rxs_link_if.sv ***
// link between the receive status device and its host controller
`timescale 1ns/1ns
interface rxs_link_if;
  import rxs_pkg::*;
  logic ctrl_wr;
  logic [31:0] ctrl_word;
  logic flush;
  logic soft_rst;
  logic fault_ack;
  logic rd_req;
  logic rd_sel;
  logic rd_hi;
  logic rd_ack;
  logic [15:0] rd_data;
  logic halted_pulse;
  logic fault_flag;
  logic [STAT_AW:0] stat_level;
  logic [DATA_AW:0] data_level;
  modport dev (
    input ctrl_wr, ctrl_word, flush, soft_rst, fault_ack, rd_req, rd_sel, rd_hi,
    output rd_ack, rd_data, halted_pulse, fault_flag, stat_level, data_level
  );
  modport host (
    output ctrl_wr, ctrl_word, flush, soft_rst, fault_ack, rd_req, rd_sel, rd_hi,
    input rd_ack, rd_data, halted_pulse, fault_flag, stat_level, data_level
  );
endinterface : rxs_link_if

// *** hdl/rxs_fifo.sv ***
// word fifo with commit and rollback of the write side
`timescale 1ns/1ns
module rxs_fifo #(
  parameter int W = 32,
  parameter int AW = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic clr,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic commit,
  input wire logic rollback,
  input wire logic rd_en,
  output logic [W-1:0] rd_data,
  output logic [AW:0] count,
  output logic full,
  output logic empty
);
  logic [W-1:0] mem [0:(1<<AW)-1];
  logic [AW:0] wr_ptr;
  logic [AW:0] cmt_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr;
  generate
    if (AW < 1 || W < 1)
    begin : g_chk
      $error("rxs_fifo: bad width or depth");
    end
  endgenerate
  // the reader only sees committed words, so a dropped frame never leaks out
  assign full = (wr_ptr - rd_ptr) == (AW + 1)'(1 << AW);
  assign empty = cmt_ptr == rd_ptr;
  assign count = cmt_ptr - rd_ptr;
  assign rd_data = mem[rd_ptr[AW-1:0]];
  assign next_wr = (wr_en && !full) ? wr_ptr + 1'b1 : wr_ptr;
  always_ff @(posedge mclk)
  begin
    if (wr_en && !full)
    begin
      mem[wr_ptr[AW-1:0]] <= wr_data;
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_ptr <= '0;
      cmt_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (clr)
    begin
      wr_ptr <= '0;
      cmt_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= rollback ? cmt_ptr : next_wr;
      if (commit)
      begin
        cmt_ptr <= next_wr;
      end
      if (rd_en && !empty)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : rxs_fifo

// *** hdl/rxs_device.sv ***
// receive status builder, status and data fifos, receiver halt and fault flag
// Summary of operation
// [RULE1] reserved status bits 31,14,9:8,0 are zero
// [RULE2] bit 30 set when address filtering failed
// [RULE3] bits 29:16 carry frame size in bytes
// [RULE4] bit 15 is or of 11,7,6,1
// [RULE5] bit 13 set for broadcast destination
// [RULE6] bit 12 set on length field mismatch
// [RULE7] bit 11 runt; runts kept only with pass-bad
// [RULE8] bit 10 set for multicast destination
// [RULE9] bit 7 over 1518 bytes, never truncated
// [RULE10] bit 6 set on late collision
// [RULE11] bit 5 type over 1500, not for short runts
// [RULE12] bit 4 set on receive watchdog expiry
// [RULE13] bit 3 set when rx error seen
// [RULE14] bit 2 dribble: 4 mii, 3+ 10M, no late
// [RULE15] bit 1 crc error or rx error seen
// [RULE16] host clears enable to halt, sets to resume
// [RULE17] one halted pulse once receiver actually stops
// [RULE18] host may flush fifos while halted
// [RULE19] fault flag on underruns or status overrun
// [RULE20] host reads status word before frame data
// [RULE21] each word moves as two 16-bit reads
// [RULE22] frame data written first, status pushed last
// [RULE23] host soft-resets after an underrun
// [RULE24] fault flag holds until acknowledged
`timescale 1ns/1ns
module rxs_device
  import rxs_pkg::*;
#(
  parameter logic [13:0] WDOG_LIMIT = WDOG_BYTES
) (
  input wire logic mclk,
  input wire logic nrst,
  rxs_link_if.dev link,
  input wire logic frm_start,
  input wire logic frm_byte_valid,
  input wire logic [7:0] frm_byte,
  input wire logic frm_end,
  input wire logic frm_crc_err,
  input wire logic frm_rx_er,
  input wire logic frm_col,
  input wire logic frm_filt_fail,
  input wire logic [2:0] frm_drib_bits,
  input wire logic mii_mode,
  output logic rx_busy
);
  generate
    if (WDOG_LIMIT < 14'h0800 || WDOG_LIMIT > 14'h0a00)
    begin : g_chk
      $error("rxs_device: watchdog limit out of range");
    end
  endgenerate
  rxs_rx_e state;
  logic rx_en;
  logic pass_bad;
  logic [13:0] cnt;
  logic [15:0] len_type;
  logic bcast;
  logic mcast;
  logic late;
  logic rxer;
  logic dovf;
  logic [1:0] widx;
  logic [31:0] wbuf;
  logic [31:0] stat_word;
  logic stat_pend;
  logic [31:0] next_status;
  logic [13:0] payload;
  logic runt;
  logic last_rxer;
  logic last_late;
  logic drop;
  logic dpush;
  logic [31:0] dwdata;
  logic spush;
  logic clr;
  logic d_rd;
  logic s_rd;
  logic [31:0] d_out;
  logic [31:0] s_out;
  logic d_full;
  logic d_empty;
  logic s_full;
  logic s_empty;
  logic [DATA_AW:0] d_cnt;
  logic [STAT_AW:0] s_cnt;
  logic [15:0] d_hold;
  logic [15:0] s_hold;
  logic underrun;
  logic overrun;
  // rx_er or a collision in the closing cycle still counts for this frame
  assign last_rxer = rxer | frm_rx_er;
  assign last_late = late | (frm_col && cnt >= RUNT_BYTES);
  assign payload = cnt - OVH_BYTES;
  assign runt = stat_word[ST_RUNT];
  always_comb
  begin
    next_status = '0; // see [RULE1]
    next_status[ST_FILT] = frm_filt_fail; // see [RULE2]
    next_status[ST_LEN_MSB:ST_LEN_LSB] = cnt; // see [RULE3]
    next_status[ST_BCAST] = bcast && cnt >= DEST_BYTES; // see [RULE5]
    next_status[ST_MCAST] = mcast && !(bcast && cnt >= DEST_BYTES); // see [RULE8]
    next_status[ST_RUNT] = cnt < RUNT_BYTES; // see [RULE7]
    next_status[ST_LONG] = cnt > MAX_BYTES; // see [RULE9]
    next_status[ST_LATE] = last_late; // see [RULE10]
    next_status[ST_TYPE] = cnt >= MIN_TYPE_BYTES && len_type > TYPE_MAX; // see [RULE11]
    // padded short payloads are not a mismatch
    next_status[ST_LENMIS] = cnt >= OVH_BYTES && len_type <= TYPE_MAX && 16'(payload) != len_type
      && !(payload == MIN_PAYLOAD && len_type < 16'(MIN_PAYLOAD)); // see [RULE6]
    next_status[ST_WDOG] = cnt > WDOG_LIMIT; // see [RULE12]
    next_status[ST_MIIERR] = last_rxer; // see [RULE13]
    next_status[ST_DRIB] = !last_late
      && (mii_mode ? frm_drib_bits == DRIB_MII : frm_drib_bits >= DRIB_10M); // see [RULE14]
    next_status[ST_CRC] = frm_crc_err | last_rxer; // see [RULE15]
    next_status[ST_ERRSUM] = next_status[ST_RUNT] | next_status[ST_LONG]
      | next_status[ST_LATE] | next_status[ST_CRC]; // see [RULE4]
  end
  assign clr = link.soft_rst | (link.flush && state == RX_HALTED); // see [RULE18]
  // bytes pack little-endian; a partial last word is pushed at frame end
  assign dpush = rx_busy && ((frm_byte_valid && widx == 2'h3) || (frm_end && widx != 2'h0)); // see [RULE22]
  assign dwdata = frm_byte_valid ? {frm_byte, wbuf[23:0]} : wbuf;
  // data commits only with the status push, one cycle after the frame ends
  // an overflowed frame loses its data but keeps its status, so the watchdog bit still reaches the host
  assign drop = runt && !pass_bad; // see [RULE7]
  assign spush = stat_pend && !drop; // see [RULE22]
  assign d_rd = link.rd_req && !link.rd_sel && !link.rd_hi;
  assign s_rd = link.rd_req && link.rd_sel && !link.rd_hi;
  assign underrun = (d_rd && d_empty) || (s_rd && s_empty); // see [RULE19]
  assign overrun = spush && s_full; // see [RULE19]
  rxs_fifo #(.W(32), .AW(DATA_AW)) u_data (
    .mclk(mclk), .nrst(nrst), .clr(clr), .wr_en(dpush), .wr_data(dwdata),
    .commit(spush && !dovf), .rollback(stat_pend && (drop || dovf)), .rd_en(d_rd), .rd_data(d_out), // see [RULE12]
    .count(d_cnt), .full(d_full), .empty(d_empty)
  );
  rxs_fifo #(.W(32), .AW(STAT_AW)) u_stat (
    .mclk(mclk), .nrst(nrst), .clr(clr), .wr_en(spush), .wr_data(stat_word),
    .commit(spush), .rollback(1'b0), .rd_en(s_rd), .rd_data(s_out),
    .count(s_cnt), .full(s_full), .empty(s_empty)
  );
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_en <= 1'b0;
      pass_bad <= 1'b0;
    end
    else if (link.ctrl_wr)
    begin
      rx_en <= link.ctrl_word[CR_RECEIVE_ENABLE_BIT]; // see [RULE16]
      pass_bad <= link.ctrl_word[CR_PASSBAD];
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_busy <= 1'b0;
      cnt <= '0;
      len_type <= '0;
      bcast <= 1'b0;
      mcast <= 1'b0;
      late <= 1'b0;
      rxer <= 1'b0;
      dovf <= 1'b0;
      widx <= '0;
      wbuf <= '0;
    end
    else if (link.soft_rst)
    begin
      rx_busy <= 1'b0;
      widx <= '0;
    end
    else if (frm_start && state == RX_RUN && !rx_busy)
    begin
      rx_busy <= 1'b1;
      cnt <= '0;
      len_type <= '0;
      bcast <= 1'b1;
      mcast <= 1'b0;
      late <= 1'b0;
      rxer <= 1'b0;
      dovf <= 1'b0;
      widx <= '0;
      wbuf <= '0;
    end
    else if (rx_busy)
    begin
      if (frm_byte_valid)
      begin
        cnt <= (cnt == CNT_MAX) ? cnt : cnt + 1'b1; // see [RULE9]
        if (cnt < DEST_BYTES)
        begin
          bcast <= bcast && frm_byte == BCAST_BYTE;
        end
        if (cnt == '0)
        begin
          mcast <= frm_byte[0];
        end
        if (cnt == LT_HI_BYTE)
        begin
          len_type[15:8] <= frm_byte;
        end
        if (cnt == LT_LO_BYTE)
        begin
          len_type[7:0] <= frm_byte;
        end
        wbuf[8*widx +: 8] <= frm_byte;
        widx <= widx + 1'b1;
      end
      if (dpush && d_full)
      begin
        dovf <= 1'b1;
      end
      rxer <= last_rxer;
      late <= last_late;
      if (frm_end)
      begin
        rx_busy <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_pend <= 1'b0;
      stat_word <= '0;
    end
    else
    begin
      stat_pend <= rx_busy && frm_end && !link.soft_rst;
      if (rx_busy && frm_end)
      begin
        stat_word <= next_status;
      end
    end
  end
  // a frame in progress finishes before the receiver counts as halted
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= RX_HALTED;
      link.halted_pulse <= 1'b0;
    end
    else
    begin
      link.halted_pulse <= 1'b0;
      case (state)
        RX_RUN:
        begin
          if (!rx_en)
          begin
            state <= RX_STOPPING;
          end
        end
        RX_STOPPING:
        begin
          if (!rx_busy && !stat_pend)
          begin
            state <= RX_HALTED;
            link.halted_pulse <= 1'b1; // see [RULE17]
          end
        end
        RX_HALTED:
        begin
          if (rx_en)
          begin
            state <= RX_RUN; // see [RULE16]
          end
        end
        default:
        begin
          state <= RX_HALTED;
        end
      endcase
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      link.fault_flag <= 1'b0;
    end
    else if (underrun || overrun)
    begin
      link.fault_flag <= 1'b1; // see [RULE19]
    end
    else if (link.fault_ack || link.soft_rst)
    begin
      link.fault_flag <= 1'b0; // see [RULE24]
    end
  end
  // low half pops the word; the high half comes from the hold register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      link.rd_ack <= 1'b0;
      link.rd_data <= '0;
      d_hold <= '0;
      s_hold <= '0;
    end
    else
    begin
      link.rd_ack <= link.rd_req;
      if (link.rd_req && link.rd_hi)
      begin
        link.rd_data <= link.rd_sel ? s_hold : d_hold; // see [RULE21]
      end
      else if (link.rd_req)
      begin
        // an underrun answers zero and leaves alignment to the host
        link.rd_data <= link.rd_sel ? (s_empty ? '0 : s_out[15:0]) : (d_empty ? '0 : d_out[15:0]); // see [RULE21]
        if (s_rd && !s_empty)
        begin
          s_hold <= s_out[31:16];
        end
        if (d_rd && !d_empty)
        begin
          d_hold <= d_out[31:16];
        end
      end
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      link.stat_level <= '0;
      link.data_level <= '0;
    end
    else
    begin
      link.stat_level <= s_cnt;
      link.data_level <= d_cnt;
    end
  end
endmodule : rxs_device

// *** hdl/rxs_host.sv ***
// host controller: software registers, word fetch over two half reads
`timescale 1ns/1ns
module rxs_host
  import rxs_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  rxs_link_if.host link,
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata
);
  rxs_host_e state;
  logic ctl_en;
  logic ctl_pb;
  logic halted_seen;
  logic [15:0] lo_half;
  logic [31:0] sword;
  logic [31:0] dword;
  logic ctrl_hit;
  assign ctrl_hit = sw_wr && sw_addr == SW_CTRL;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctl_en <= CTRL_RST[C_EN];
      ctl_pb <= CTRL_RST[C_PB];
      link.ctrl_wr <= 1'b0;
      link.ctrl_word <= '0;
      link.flush <= 1'b0;
      link.soft_rst <= 1'b0;
      link.fault_ack <= 1'b0;
    end
    else
    begin
      link.ctrl_wr <= ctrl_hit;
      link.flush <= ctrl_hit && sw_wdata[C_FLUSH]; // see [RULE18]
      link.soft_rst <= ctrl_hit && sw_wdata[C_SRST]; // see [RULE23]
      link.fault_ack <= ctrl_hit && sw_wdata[C_ACK];
      if (ctrl_hit)
      begin
        ctl_en <= sw_wdata[C_EN];
        ctl_pb <= sw_wdata[C_PB];
        link.ctrl_word <= '0;
        link.ctrl_word[CR_RECEIVE_ENABLE_BIT] <= sw_wdata[C_EN]; // see [RULE16]
        link.ctrl_word[CR_PASSBAD] <= sw_wdata[C_PB];
      end
    end
  end
  // one fetch at a time; only the status word is fetched when both are asked for
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= H_IDLE;
      link.rd_req <= 1'b0;
      link.rd_sel <= 1'b0;
      link.rd_hi <= 1'b0;
      lo_half <= '0;
      sword <= '0;
      dword <= '0;
    end
    else
    begin
      link.rd_req <= 1'b0;
      case (state)
        H_IDLE:
        begin
          if (ctrl_hit && (sw_wdata[C_FSTAT] || sw_wdata[C_FDATA]))
          begin
            link.rd_req <= 1'b1;
            link.rd_sel <= sw_wdata[C_FSTAT]; // see [RULE20]
            link.rd_hi <= 1'b0;
            state <= H_LO;
          end
        end
        H_LO:
        begin
          if (link.rd_ack)
          begin
            lo_half <= link.rd_data;
            link.rd_req <= 1'b1;
            link.rd_hi <= 1'b1; // see [RULE21]
            state <= H_HI;
          end
        end
        H_HI:
        begin
          if (link.rd_ack)
          begin
            if (link.rd_sel)
            begin
              sword <= {link.rd_data, lo_half}; // see [RULE21]
            end
            else
            begin
              dword <= {link.rd_data, lo_half};
            end
            link.rd_hi <= 1'b0;
            state <= H_IDLE;
          end
        end
        default:
        begin
          state <= H_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      halted_seen <= 1'b0;
      sw_rdata <= '0;
    end
    else
    begin
      // a halt pulse in the same cycle as the status read survives
      if (link.halted_pulse)
      begin
        halted_seen <= 1'b1;
      end
      else if (sw_rd && sw_addr == SW_STAT)
      begin
        halted_seen <= 1'b0;
      end
      sw_rdata <= '0;
      if (sw_rd)
      begin
        case (sw_addr)
          SW_CTRL: sw_rdata <= {30'h0, ctl_pb, ctl_en};
          SW_STAT: sw_rdata <= {6'h0, link.data_level, 3'h0, link.stat_level,
                                5'h0, link.fault_flag, halted_seen, state != H_IDLE};
          SW_SWORD: sw_rdata <= sword;
          SW_DWORD: sw_rdata <= dword;
          default: sw_rdata <= '0;
        endcase
      end
    end
  end
endmodule : rxs_host

// *** test/rxs_chk.sv ***
// concurrent checks on the link between receive device and host
`timescale 1ns/1ns
module rxs_chk
  import rxs_pkg::*;
(
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ctrl_wr,
  input wire logic [31:0] ctrl_word,
  input wire logic soft_rst,
  input wire logic fault_ack,
  input wire logic rd_req,
  input wire logic rd_hi,
  input wire logic rd_ack,
  input wire logic halted_pulse,
  input wire logic fault_flag
);
  logic en_q;
  // last enable written; a halt report is only legal after a disable
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      en_q <= 1'b0;
    else if (ctrl_wr)
      en_q <= ctrl_word[CR_RECEIVE_ENABLE_BIT];
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  sequence s_lo_req;
    rd_req && !rd_hi;
  endsequence
  sequence s_half;
    rd_req ##1 rd_ack;
  endsequence
  sequence s_hi_req;
    rd_req && rd_hi;
  endsequence
  chk_ack_one_late: assert property (rd_req |=> rd_ack)
    else $error("link answer missing one cycle after request");
  chk_ack_has_cause: assert property (rd_ack |-> $past(rd_req))
    else $error("link answer without request");
  chk_req_spacing: assert property (rd_req |=> !rd_req)
    else $error("half read issued before answer");
  chk_word_pair: assert property (s_lo_req |-> s_half ##1 s_hi_req)
    else $error("low half not followed by high half");
  chk_halt_single: assert property (halted_pulse |=> !halted_pulse)
    else $error("halted pulse longer than one cycle");
  chk_halt_after_off: assert property (halted_pulse |-> !en_q)
    else $error("halted pulse while receive enabled");
  chk_fault_holds: assert property (fault_flag && !fault_ack && !soft_rst |=> fault_flag)
    else $error("fault flag dropped without acknowledge");
  chk_fault_clears: assert property ((fault_ack || soft_rst) && !rd_req |=> !fault_flag)
    else $error("fault flag not cleared");
endmodule : rxs_chk

// *** test/tb_top.sv ***
// self-checking bench: device and host joined over the link
`timescale 1ns/1ns
module tb_top
  import rxs_pkg::*;
;
  logic mclk, nrst, frm_start, frm_byte_valid, frm_end, frm_crc_err, frm_rx_er, frm_col, frm_filt_fail, mii_mode;
  logic [7:0] frm_byte;
  logic [2:0] frm_drib_bits;
  logic [3:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, ctl, x;
  logic sw_wr, sw_rd, rx_busy;
  int fails, tests_run, dw;
  logic [31:0] exp_st[$];
  int dn[$];
  logic [7:0] dq[$];
  rxs_link_if link ();
  rxs_device #(.WDOG_LIMIT(14'h0800)) rxs_device_i (.mclk, .nrst, .link(link), .frm_start, .frm_byte_valid,
    .frm_byte, .frm_end, .frm_crc_err, .frm_rx_er, .frm_col, .frm_filt_fail, .frm_drib_bits, .mii_mode, .rx_busy);
  rxs_host rxs_host_i (.mclk, .nrst, .link(link), .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
  rxs_chk rxs_chk_i (.mclk, .nrst, .ctrl_wr(link.ctrl_wr), .ctrl_word(link.ctrl_word), .soft_rst(link.soft_rst),
    .fault_ack(link.fault_ack), .rd_req(link.rd_req), .rd_hi(link.rd_hi), .rd_ack(link.rd_ack),
    .halted_pulse(link.halted_pulse), .fault_flag(link.fault_flag));
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  task automatic stop_test();
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge mclk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge mclk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask : rd
  task automatic fetch(input logic dat, output logic [31:0] w);
    logic [31:0] s;
    wr(SW_CTRL, ctl | (32'h1 << (dat ? C_FDATA : C_FSTAT)));
    s = 32'h1;
    for (int i = 0; i < 20 && s[0] !== 1'b0; i++)
      rd(SW_STAT, s);
    rd(dat ? SW_DWORD : SW_SWORD, w);
  endtask : fetch
  task automatic lvl(input int st, input int dwc);
    logic [31:0] s;
    rd(SW_STAT, s);
    chk("stat_level", st, {27'h0, s[12:8]});
    chk("data_level", dwc, {22'h0, s[25:16]});
  endtask : lvl
  task automatic fault(input logic e);
    logic [31:0] s;
    rd(SW_STAT, s);
    chk("fault", {31'h0, e}, {31'h0, s[2]});
  endtask : fault
  task automatic sreset();
    wr(SW_CTRL, ctl | (32'h1 << C_SRST));
    exp_st.delete();
    dn.delete();
    dq.delete();
    dw = 0;
  endtask : sreset
  // model of one frame: builds the bytes, predicts the status word, then drives the receive side
  task automatic frame(input int n, input logic [15:0] lf, input int dk, input logic cl, input logic ce,
    input logic er, input logic ff, input logic [2:0] db, input logic m);
    logic [7:0] b[];
    logic [31:0] s;
    logic lt;
    b = new[n];
    for (int i = 0; i < n; i++)
    begin
      s = rnd();
      b[i] = (dk == 2 && i < 6) ? 8'hff : s[7:0];
    end
    if (dk < 2)
    begin
      b[0][0] = (dk == 1);
      b[1] = 8'h00;
    end
    if (n > 13)
    begin
      b[12] = lf[15:8];
      b[13] = lf[7:0];
    end
    lt = cl && n >= 64;
    s = 32'h0;
    s[30] = ff;
    s[29:16] = n[13:0];
    s[13] = dk == 2;
    s[12] = lf <= 16'h05dc && n >= 18 && n - 18 != lf && !(n - 18 == 46 && lf < 46);
    s[11] = n < 64;
    s[10] = dk == 1;
    s[7] = n > 1518;
    s[6] = lt;
    s[5] = n >= 14 && lf > 16'h05dc;
    s[4] = n > 2048;
    s[3] = er;
    s[2] = (m ? db == 3'h4 : db >= 3'h3) && !lt;
    s[1] = ce || er;
    s[15] = s[11] | s[7] | s[6] | s[1];
    // too-large frames overflow the data fifo and keep only their status
    if (ctl[0] && !(n < 64 && !ctl[1]))
    begin
      exp_st.push_back(s);
      dn.push_back(n <= 2048 ? n : 0);
      if (n <= 2048)
      begin
        foreach (b[i])
          dq.push_back(b[i]);
        dw += (n + 3) / 4;
      end
    end
    // a new enable needs a few cycles to reach the receiver
    repeat (4) @(posedge mclk);
    frm_start <= 1'b1;
    mii_mode <= m;
    @(posedge mclk);
    frm_start <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      frm_byte_valid <= 1'b1;
      frm_byte <= b[i];
      frm_rx_er <= er && i == n / 2;
      @(posedge mclk);
      if (i == 0)
        chk("rx_busy", {31'h0, ctl[0]}, {31'h0, rx_busy});
    end
    frm_byte_valid <= 1'b0;
    frm_rx_er <= 1'b0;
    frm_end <= 1'b1;
    frm_crc_err <= ce;
    frm_filt_fail <= ff;
    frm_drib_bits <= db;
    frm_col <= cl;
    @(posedge mclk);
    frm_end <= 1'b0;
    frm_col <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : frame
  task automatic drain();
    logic [31:0] w, e, m;
    int n;
    lvl(exp_st.size(), dw);
    while (exp_st.size() > 0)
    begin
      fetch(1'b0, w);
      e = exp_st.pop_front();
      chk("st_hi", e[31:16], w[31:16]);
      chk("st_mid", e[15:10], w[15:10]);
      chk("st_lo", e[9:0], w[9:0]);
      n = dn.pop_front();
      for (int k = 0; k < n; k += 4)
      begin
        fetch(1'b1, w);
        e = 32'h0;
        m = 32'h0;
        for (int j = 0; j < 4; j++)
          if (k + j < n)
          begin
            e[8*j +: 8] = dq.pop_front();
            m[8*j +: 8] = 8'hff;
          end
        chk("data", e, w & m);
      end
    end
    dw = 0;
    lvl(0, 0);
  endtask : drain
  initial
  begin
    #(80000 * 100);
    fails++;
    stop_test();
  end
  initial
  begin
    logic [31:0] s, w;
    logic [15:0] lf;
    int n;
    {frm_start, frm_byte_valid, frm_end, frm_crc_err, frm_rx_er, frm_col, frm_filt_fail, mii_mode} = 8'h00;
    {frm_byte, frm_drib_bits, sw_addr, sw_wdata, sw_wr, sw_rd} = '0;
    nrst = 1'b0;
    ctl = 32'h0;
    x = 32'hc8b80084;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    rd(SW_CTRL, s);
    chk("ctrl_reset", CTRL_RST, s);
    frame(80, 16'h003e, 0, 0, 0, 0, 0, 3'h0, 0);
    lvl(0, 0);
    ctl = 32'h3;
    wr(SW_CTRL, ctl);
    for (int i = 0; i < 9; i++)
    begin
      n = 64 + rnd() % 60;
      lf = 16'(n - 18 + i % 3);
      s = rnd();
      frame(n, lf, i / 3, 0, s[0], s[1], s[2], s[5:3], s[6]);
    end
    drain();
    frame(20, 16'h0600, 2, 0, 0, 0, 0, 3'h3, 0);
    frame(10, 16'h0600, 1, 0, 0, 0, 1, 3'h2, 0);
    frame(100, 16'h0052, 0, 1, 0, 0, 0, 3'h4, 1);
    frame(1600, 16'h0800, 0, 0, 1, 0, 0, 3'h4, 1);
    drain();
    frame(2100, 16'h0800, 2, 0, 0, 0, 0, 3'h0, 0);
    drain();
    ctl = 32'h1;
    wr(SW_CTRL, ctl);
    frame(30, 16'h000c, 0, 0, 0, 0, 0, 3'h0, 0);
    rd(SW_STAT, s);
    chk("runt_dropped", 32'h0, {22'h0, s[25:16]});
    sreset();
    ctl = 32'h3;
    wr(SW_CTRL, ctl);
    frame(70, 16'h0034, 0, 0, 0, 0, 0, 3'h0, 0);
    frame(90, 16'h0048, 1, 0, 0, 0, 0, 3'h0, 0);
    ctl = 32'h0;
    wr(SW_CTRL, ctl);
    s = 32'h0;
    for (int i = 0; i < 10 && s[1] !== 1'b1; i++)
      rd(SW_STAT, s);
    chk("halted_seen", 32'h1, {31'h0, s[1]});
    rd(SW_STAT, s);
    chk("halted_again", 32'h0, {31'h0, s[1]});
    lvl(2, dw);
    wr(SW_CTRL, ctl | (32'h1 << C_FLUSH));
    // levels follow the fifos a cycle late
    repeat (2) @(posedge mclk);
    lvl(0, 0);
    sreset();
    fetch(1'b0, w);
    chk("underrun_low", 32'h0, {16'h0, w[15:0]});
    fault(1'b1);
    fault(1'b1);
    wr(SW_CTRL, ctl | (32'h1 << C_ACK));
    fault(1'b0);
    fetch(1'b1, w);
    fault(1'b1);
    sreset();
    fault(1'b0);
    ctl = 32'h3;
    wr(SW_CTRL, ctl);
    // one more status than the status fifo holds
    for (int i = 0; i < 17; i++)
      frame(64, 16'h002e, 0, 0, 0, 0, 0, 3'h0, 0);
    rd(SW_STAT, s);
    chk("overrun_level", 32'h10, {27'h0, s[12:8]});
    fault(1'b1);
    sreset();
    frame(200, 16'h00b6, 1, 0, 0, 0, 0, 3'h0, 0);
    drain();
    stop_test();
  end
endmodule : tb_top
